// ===== verilog/gpc_port.sv
// gpc_port: eight-pin general-purpose port with change interrupt
// assumes: AXI4-Lite master on the core clock; pads resolve the
// drive, enable and pull-up signals; peripherals drive their overrides
`timescale 1ns/10ps
module gpc_port
    import gpc_pkg::*;
(
    input wire logic CORE_CLK,                        // core clock, 40 MHz
    input wire logic RST,                             // async reset, active high
    // AXI4-Lite slave
    input wire logic AWVALID,                         // write address valid
    output logic AWREADY,                             // write address ready
    input wire logic [31:0] AWADDR,                   // write address
    input wire logic WVALID,                          // write data valid
    output logic WREADY,                              // write data ready
    input wire logic [31:0] WDATA,                    // write data
    input wire logic [3:0] WSTRB,                     // write byte strobes
    output logic BVALID,                              // write response valid
    input wire logic BREADY,                          // write response ready
    output logic [1:0] BRESP,                         // write response
    input wire logic ARVALID,                         // read address valid
    output logic ARREADY,                             // read address ready
    input wire logic [31:0] ARADDR,                   // read address
    output logic RVALID,                              // read data valid
    input wire logic RREADY,                          // read data ready
    output logic [31:0] RDATA,                        // read data
    output logic [1:0] RRESP,                         // read response
    // pins
    input wire logic [gpc_pkg::PIN_COUNT-1:0] PIN_I,  // pin levels
    output logic [gpc_pkg::PIN_COUNT-1:0] PIN_O,      // pin drive value
    output logic [gpc_pkg::PIN_COUNT-1:0] PIN_OE,     // high while driving
    output logic [gpc_pkg::PIN_COUNT-1:0] PIN_PU,     // weak pull-up on
    // peripheral overrides
    input wire logic [gpc_pkg::PIN_COUNT-1:0] PERIPH_EN,  // peripheral owns pin
    input wire logic [gpc_pkg::PIN_COUNT-1:0] PERIPH_DIR, // one forces input
    input wire logic [gpc_pkg::PIN_COUNT-1:0] PERIPH_OUT, // peripheral drive
    input wire logic PROG_MODE,                       // serial programming mode
    input wire logic PROG_DATA_OE,                    // programmer drives data pin
    input wire logic PROG_DATA_OUT,                   // programming data out
    // peripheral inputs and status
    output logic EXT_IRQ_IN,                          // external interrupt level
    output logic TMR_CLK_IN,                          // timer clock input level
    output logic OSC_IN,                              // timer oscillator input level
    output logic CAPTURE_IN,                          // capture input level
    output logic PROG_CLK_IN,                         // programming clock level
    output logic PROG_DATA_IN,                        // programming data level
    output logic SECONDARY_OSC_ENABLE,                // oscillator enable to timer
    output logic PORT_CHANGE_IRQ,                     // flag gated by enable
    output logic WAKE                                 // wake request from sleep
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0] latch;         // output latch
        logic [7:0] dir;           // port_direction_mask
        logic [7:0] option;        // option configuration
        logic [7:0] intctl;        // interrupt_control_reg
        logic [7:0] periph;        // peripheral pin control
        logic aw_full;             // write address held
        logic [ADDR_W-1:0] aw_addr; // held write address
        logic w_full;              // write data held
        logic [7:0] w_data;        // held write data, low byte
        logic w_lane0;             // low byte strobed
        logic awready;             // write address ready
        logic wready;              // write data ready
        logic bvalid;              // write response valid
        logic [1:0] bresp;         // write response
        logic arready;             // read address ready
        logic rvalid;              // read data valid
        logic [31:0] rdata;        // read data
        logic [1:0] rresp;         // read response
        logic [7:0] pin_o;         // pin drive value
        logic [7:0] pin_oe;        // pin drive enable
        logic [7:0] pin_pu;        // pull-up enable
        logic [5:0] periph_in;     // synchronised peripheral inputs
        logic osc_en;              // oscillator enable out
        logic irq;                 // interrupt request
        logic wake;                // wake request
    } gpc_port_t;

    gpc_port_t s_q; // registered state
    gpc_port_t s_d; // next state

    logic [PIN_COUNT-1:0] pins_sync;        // synchronised pins
    logic [PIN_COUNT-1:0] dir_eff;          // effective direction, one is input
    logic [PIN_COUNT-1:0] out_val;          // effective drive value
    logic [WATCH_COUNT-1:0] watch_in_mask;  // watched pins that are inputs
    logic refresh;                          // data register accessed this cycle
    logic mismatch;                         // change detected
    logic do_write;                         // address and data both held
    logic rd_take;                          // read address taken
    logic [ADDR_W-1:0] rd_addr;             // read offset

    // ------------------------------------------------------------
    // pin input synchroniser
    // ------------------------------------------------------------
    gpc_sync u_sync (
        .CORE_CLK(CORE_CLK),
        .RST(RST),
        .pins_in(PIN_I),
        .pins_sync(pins_sync)
    );

    // ------------------------------------------------------------
    // change detector on the upper pins
    // ------------------------------------------------------------
    gpc_change u_change (
        .CORE_CLK(CORE_CLK),
        .RST(RST),
        .watch_in(pins_sync[WATCH_LO +: WATCH_COUNT]),
        .in_mask(watch_in_mask),
        .refresh(refresh),
        .mismatch(mismatch)
    );

    // ------------------------------------------------------------
    // effective direction and drive per pin
    // ------------------------------------------------------------
    // priority: programming mode, oscillator, peripheral, direction bit
    always_comb begin
        for (int i = 0; i < PIN_COUNT; i++) begin
            dir_eff[i] = s_q.dir[i];
            out_val[i] = s_q.latch[i];
            if (PERIPH_EN[i]) begin
                dir_eff[i] = PERIPH_DIR[i];
                out_val[i] = PERIPH_OUT[i];
            end
        end
        if (s_q.periph[OSC_EN_BIT]) begin
            dir_eff[OSC_OUT_PIN] = 1'b1;
            dir_eff[OSC_IN_PIN] = 1'b1;
        end
        if (PROG_MODE) begin
            dir_eff[PROG_CLK_PIN] = 1'b1;
            dir_eff[PROG_DATA_PIN] = ~PROG_DATA_OE;
            out_val[PROG_DATA_PIN] = PROG_DATA_OUT;
        end
        watch_in_mask = dir_eff[WATCH_LO +: WATCH_COUNT];
    end

    // ------------------------------------------------------------
    // bus handshakes and access decode
    // ------------------------------------------------------------
    assign do_write = s_q.aw_full & s_q.w_full;
    assign rd_take = ARVALID & s_q.arready;
    assign rd_addr = ARADDR[ADDR_W-1:0];
    // read or write of the data register refreshes the reference
    assign refresh = (rd_take & (rd_addr == ADDR_DATA))
        | (do_write & (s_q.aw_addr == ADDR_DATA));

    // ------------------------------------------------------------
    // next-state logic
    // ------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        // write address and data may arrive in either order
        if (AWVALID && s_q.awready) begin
            s_d.aw_full = 1'b1;
            s_d.aw_addr = AWADDR[ADDR_W-1:0];
        end
        if (WVALID && s_q.wready) begin
            s_d.w_full = 1'b1;
            s_d.w_data = WDATA[7:0];
            s_d.w_lane0 = WSTRB[0];
        end
        if (BREADY && s_q.bvalid) begin
            s_d.bvalid = 1'b0;
        end
        // perform the write once both halves are held
        if (do_write) begin
            s_d.aw_full = 1'b0;
            s_d.w_full = 1'b0;
            s_d.bvalid = 1'b1;
            s_d.bresp = is_mapped(s_q.aw_addr) ? RESP_OKAY : RESP_DECERR;
            if (s_q.w_lane0) begin
                unique case (s_q.aw_addr)
                    ADDR_DATA: begin
                        s_d.latch = s_q.w_data;
                    end
                    ADDR_DIR: begin
                        s_d.dir = s_q.w_data;
                    end
                    ADDR_OPTION: begin
                        s_d.option = s_q.w_data & OPTION_RST;
                    end
                    ADDR_INTCTL: begin
                        s_d.intctl = s_q.w_data;
                    end
                    ADDR_PERIPH: begin
                        s_d.periph = s_q.w_data & 8'h01;
                    end
                    default: begin
                        // unmapped: nothing stored
                    end
                endcase
            end
        end
        // mismatch sets the flag every cycle and beats a clear
        if (mismatch) begin
            s_d.intctl[FLAG_BIT] = 1'b1;
        end
        s_d.awready = ~s_d.aw_full & ~s_d.bvalid;
        s_d.wready = ~s_d.w_full & ~s_d.bvalid;
        // read channel, one outstanding read
        if (RREADY && s_q.rvalid) begin
            s_d.rvalid = 1'b0;
        end
        if (rd_take) begin
            s_d.rvalid = 1'b1;
            s_d.rresp = is_mapped(rd_addr) ? RESP_OKAY : RESP_DECERR;
            unique case (rd_addr)
                ADDR_DATA: begin
                    s_d.rdata = {24'h00_0000, pins_sync};
                end
                ADDR_DIR: begin
                    s_d.rdata = {24'h00_0000, s_q.dir};
                end
                ADDR_OPTION: begin
                    s_d.rdata = {24'h00_0000, s_q.option};
                end
                ADDR_INTCTL: begin
                    s_d.rdata = {24'h00_0000, s_q.intctl};
                end
                ADDR_PERIPH: begin
                    s_d.rdata = {24'h00_0000, s_q.periph};
                end
                default: begin
                    s_d.rdata = 32'h0000_0000;
                end
            endcase
        end
        s_d.arready = ~s_d.rvalid;
        // pad controls, pull-up only on inputs while enabled
        s_d.pin_o = out_val;
        s_d.pin_oe = ~dir_eff;
        s_d.pin_pu = dir_eff & {PIN_COUNT{~s_q.option[PULLUP_DIS_BIT]}};
        // synchronised levels to the sharing peripherals
        s_d.periph_in = {pins_sync[PROG_DATA_PIN], pins_sync[PROG_CLK_PIN],
            pins_sync[CAPCMP_PIN], pins_sync[OSC_IN_PIN],
            pins_sync[OSC_OUT_PIN], pins_sync[EXT_IRQ_PIN]};
        s_d.osc_en = s_q.periph[OSC_EN_BIT];
        // interrupt and wake from the flag just computed
        s_d.irq = s_d.intctl[FLAG_BIT] & s_d.intctl[IRQ_EN_BIT];
        s_d.wake = s_d.intctl[FLAG_BIT] & s_d.intctl[IRQ_EN_BIT];
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            s_q <= '0;
            s_q.latch <= LATCH_RST;
            s_q.dir <= DIR_RST;
            s_q.option <= OPTION_RST;
            s_q.intctl <= INTCTL_RST;
            s_q.periph <= PERIPH_RST;
        end else begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------
    // outputs, all from the state register
    // ------------------------------------------------------------
    assign AWREADY = s_q.awready;
    assign WREADY = s_q.wready;
    assign BVALID = s_q.bvalid;
    assign BRESP = s_q.bresp;
    assign ARREADY = s_q.arready;
    assign RVALID = s_q.rvalid;
    assign RDATA = s_q.rdata;
    assign RRESP = s_q.rresp;
    assign PIN_O = s_q.pin_o;
    assign PIN_OE = s_q.pin_oe;
    assign PIN_PU = s_q.pin_pu;
    assign EXT_IRQ_IN = s_q.periph_in[0];
    assign TMR_CLK_IN = s_q.periph_in[1];
    assign OSC_IN = s_q.periph_in[2];
    assign CAPTURE_IN = s_q.periph_in[3];
    assign PROG_CLK_IN = s_q.periph_in[4];
    assign PROG_DATA_IN = s_q.periph_in[5];
    assign SECONDARY_OSC_ENABLE = s_q.osc_en;
    assign PORT_CHANGE_IRQ = s_q.irq;
    assign WAKE = s_q.wake;
endmodule

// ===== verilog/gpc_pkg.sv
// gpc_pkg: constants for the eight-pin port with change detection
// assumes: included by every design file of the port block; 32-bit AXI4-Lite data
package gpc_pkg;

    // ------------------------------------------------------------
    // geometry
    // ------------------------------------------------------------
    localparam int unsigned PIN_COUNT = 8;   // pins on the port
    localparam int unsigned WATCH_COUNT = 4; // pins with change detection
    localparam int unsigned WATCH_LO = 4;    // lowest watched pin
    localparam int unsigned ADDR_W = 8;      // decoded address bits

    // ------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_DATA = 8'h00;   // pins on read, output latch on write
    localparam logic [7:0] ADDR_DIR = 8'h04;    // direction mask, one means input
    localparam logic [7:0] ADDR_OPTION = 8'h08; // option configuration
    localparam logic [7:0] ADDR_INTCTL = 8'h0C; // interrupt control
    localparam logic [7:0] ADDR_PERIPH = 8'h10; // peripheral pin control

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int unsigned PULLUP_DIS_BIT = 7; // pullup_disable_n in option
    localparam int unsigned FLAG_BIT = 0;       // port_change_flag in intctl
    localparam int unsigned IRQ_EN_BIT = 3;     // port_change_irq_enable in intctl
    localparam int unsigned OSC_EN_BIT = 0;     // secondary_osc_enable in periph
    localparam int unsigned EXT_IRQ_PIN = 0;    // ext_irq_pin
    localparam int unsigned OSC_OUT_PIN = 1;    // timer_osc_out_clk_in_pin
    localparam int unsigned OSC_IN_PIN = 2;     // timer_osc_in_pin
    localparam int unsigned CAPCMP_PIN = 3;     // capture_compare_pin
    localparam int unsigned PROG_CLK_PIN = 6;   // prog_clock_pin
    localparam int unsigned PROG_DATA_PIN = 7;  // prog_data_pin

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [7:0] LATCH_RST = 8'h00;  // output latch
    localparam logic [7:0] DIR_RST = 8'hFF;    // all pins input
    localparam logic [7:0] OPTION_RST = 8'h80; // pull-ups disabled
    localparam logic [7:0] INTCTL_RST = 8'h00; // flag and enable clear
    localparam logic [7:0] PERIPH_RST = 8'h00; // oscillator off

    // ------------------------------------------------------------
    // bus responses
    // ------------------------------------------------------------
    localparam logic [1:0] RESP_OKAY = 2'h0;   // accepted
    localparam logic [1:0] RESP_DECERR = 2'h3; // unmapped address

    // true when the offset names a register of the port
    function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
        return (a == ADDR_DATA) || (a == ADDR_DIR) || (a == ADDR_OPTION)
            || (a == ADDR_INTCTL) || (a == ADDR_PERIPH);
    endfunction

endpackage

// ===== verilog/gpc_sync.sv
// gpc_sync: two-stage synchroniser for the pin inputs
// assumes: one clock; pins change at any time relative to it
`timescale 1ns/10ps
module gpc_sync
    import gpc_pkg::*;
(
    input wire logic CORE_CLK,                 // core clock
    input wire logic RST,                      // async reset, active high
    input wire logic [PIN_COUNT-1:0] pins_in,  // raw pin levels
    output logic [PIN_COUNT-1:0] pins_sync     // synchronised levels
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [PIN_COUNT-1:0] stage1; // first stage, read only by stage2
        logic [PIN_COUNT-1:0] stage2; // second stage
    } gpc_sync_t;

    gpc_sync_t s_q; // registered state
    gpc_sync_t s_d; // next state

    // shift each pin through both stages
    always_comb begin
        s_d = s_q;
        s_d.stage1 = pins_in;
        s_d.stage2 = s_q.stage1;
    end

    // register the state
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign pins_sync = s_q.stage2;
endmodule

// ===== verilog/gpc_change.sv
// gpc_change: mismatch detector for the four watched pins
// assumes: pins already synchronised; refresh is a one-cycle pulse
`timescale 1ns/10ps
module gpc_change
    import gpc_pkg::*;
(
    input wire logic CORE_CLK,                   // core clock
    input wire logic RST,                        // async reset, active high
    input wire logic [WATCH_COUNT-1:0] watch_in, // synchronised watched pins
    input wire logic [WATCH_COUNT-1:0] in_mask,  // one where the pin is an input
    input wire logic refresh,                    // data register accessed
    output logic mismatch                        // some input differs from copy
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [WATCH_COUNT-1:0] ref_val; // levels seen at the last access
    } gpc_change_t;

    gpc_change_t s_q; // registered state
    gpc_change_t s_d; // next state

    // capture a new reference on every data register access
    always_comb begin
        s_d = s_q;
        if (refresh) begin
            s_d.ref_val = watch_in;
        end
    end

    // register the state
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // compare inputs only, or the four results, end on access
    assign mismatch = (|((watch_in ^ s_q.ref_val) & in_mask)) & ~refresh;
endmodule

// ===== tb/gpc_port_checker.sv
// gpc_port_checker: timing relations at the ports of gpc_port
// assumes: bound to gpc_port; one clock, reset active high
`timescale 1ns/10ps
module gpc_port_checker (
    input wire logic CORE_CLK, RST, AWVALID, AWREADY, WVALID, WREADY, // clock, reset, writes
    input wire logic BVALID, ARVALID, ARREADY, RVALID, PROG_MODE, // answers, mode
    input wire logic EXT_IRQ_IN, SECONDARY_OSC_ENABLE, PORT_CHANGE_IRQ, WAKE, // status
    input wire logic [7:0] PIN_I, PIN_OE, PIN_PU, PERIPH_EN, PERIPH_DIR // pins
);
    logic [2:0] run_q; // edges since reset, saturating
    logic ok; // far enough from reset for delayed relations
    // count edges out of reset so $past in the checks gated by ok never looks into reset
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) run_q <= 3'h0;
        else if (run_q != 3'h7) run_q <= run_q + 3'h1;
    end
    assign ok = (run_q == 3'h7);
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (RST);
    sequence s_wr_taken; AWVALID && AWREADY && WVALID && WREADY; endsequence
    sequence s_wr_answer; !BVALID ##1 BVALID; endsequence
    a_write_answer: assert property (s_wr_taken |=> s_wr_answer)
        else $error("write answer late or early");
    a_read_answer: assert property (ARVALID && ARREADY |=> RVALID)
        else $error("read answer missing");
    a_pullup_output: assert property ((PIN_PU & PIN_OE) == 8'h00)
        else $error("pull-up on a driven pin");
    a_irq_wake_match: assert property (PORT_CHANGE_IRQ == WAKE)
        else $error("wake differs from change request");
    a_osc_pins_input: assert property (SECONDARY_OSC_ENABLE && $past(SECONDARY_OSC_ENABLE)
        |-> PIN_OE[2:1] == 2'h0) else $error("oscillator pins driven");
    a_periph_force: assert property (ok && $past(PERIPH_EN[3])
        |-> PIN_OE[3] == !$past(PERIPH_DIR[3])) else $error("override ignored");
    a_prog_clk_in: assert property (ok && $past(PROG_MODE) |-> !PIN_OE[6])
        else $error("programming clock pin driven");
    a_sync_delay: assert property (ok |-> EXT_IRQ_IN == $past(PIN_I[0], 3))
        else $error("pin level not three edges late");
endmodule
bind gpc_port gpc_port_checker u_chk (.*);

// ===== tb/gpc_pins_model.sv
// gpc_pins_model: pads and outside drivers seen by the port pins
// assumes: bench drives ext_lvl where ext_en is set
`timescale 1ns/10ps
module gpc_pins_model (
    input wire logic [7:0] pin_o, // port drive value
    input wire logic [7:0] pin_oe, // port drives the pin
    input wire logic [7:0] pin_pu, // weak pull-up on
    input wire logic [7:0] ext_lvl, // outside driver value
    input wire logic [7:0] ext_en, // outside driver active
    output logic [7:0] pin_lvl // resolved level
);
    // port wins, then outside, then pull-up; a bare pin shows no stale value
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (pin_oe[i]) pin_lvl[i] = pin_o[i];
            else if (ext_en[i]) pin_lvl[i] = ext_lvl[i];
            else if (pin_pu[i]) pin_lvl[i] = 1'h1;
            else pin_lvl[i] = ~pin_o[i];
        end
    end
endmodule

// ===== tb/test_gpio_port_with_change_interrupt.sv
// test_gpio_port_with_change_interrupt: self-checking bench for gpc_port
// assumes: gpc_pkg, design, pins model and checker compiled first
`timescale 1ns/10ps
module test_gpio_port_with_change_interrupt;
    import gpc_pkg::*;
    logic CORE_CLK = 1'h0, RST = 1'h1, AWVALID = 1'h0, WVALID = 1'h0, BREADY = 1'h0;
    logic ARVALID = 1'h0, RREADY = 1'h0, AWREADY, WREADY, BVALID, ARREADY, RVALID;
    logic [31:0] AWADDR = 32'h0, WDATA = 32'h0, ARADDR = 32'h0, RDATA;
    logic [3:0] WSTRB = 4'h1; // low byte only
    logic [1:0] BRESP, RRESP;
    logic [7:0] PIN_I, PIN_O, PIN_OE, PIN_PU, ext_lvl = 8'h00, lat;
    logic [7:0] PERIPH_EN = 8'h00, PERIPH_DIR = 8'h00, PERIPH_OUT = 8'h00;
    logic PROG_MODE = 1'h0, PROG_DATA_OE = 1'h0, PROG_DATA_OUT = 1'h0;
    logic EXT_IRQ_IN, PORT_CHANGE_IRQ, WAKE, SECONDARY_OSC_ENABLE, TMR_CLK_IN, OSC_IN;
    logic CAPTURE_IN, PROG_CLK_IN, PROG_DATA_IN;
    logic [33:0] exp_q[$]; // expected read answers {resp, data}
    logic [1:0] bexp_q[$]; // expected write responses
    int fails = 0, cmp_count = 0, seed = 32'h6979;
    gpc_port DUT (.*);
    gpc_pins_model PADS (.pin_o(PIN_O), .pin_oe(PIN_OE), .pin_pu(PIN_PU),
        .ext_lvl(ext_lvl), .ext_en(8'hFF), .pin_lvl(PIN_I));
    always #12.5 CORE_CLK = ~CORE_CLK;
    task automatic cmp(input logic [33:0] got, input logic [33:0] want);
        cmp_count++;
        if (got !== want) begin
            fails++;
            $display("CHECK FAILED t=%0t got %h want %h", $time, got, want);
        end
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] want);
        cmp({26'h0, got}, {26'h0, want});
    endtask
    // write responses, widened to the common compare
    task automatic cmp_b(input logic [1:0] got, input logic [1:0] want);
        cmp({32'h0, got}, {32'h0, want});
    endtask
    // write: address and data together, each dropped once taken
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        bexp_q.push_back(a > ADDR_PERIPH ? RESP_DECERR : RESP_OKAY);
        @(posedge CORE_CLK);
        AWVALID <= 1'h1;
        WVALID <= 1'h1;
        BREADY <= 1'h1;
        AWADDR <= {24'h0, a};
        WDATA <= {24'h0, d};
        do begin
            @(posedge CORE_CLK);
            if (AWREADY) AWVALID <= 1'h0;
            if (WREADY) WVALID <= 1'h0;
        end while (!BVALID);
        BREADY <= 1'h0;
    endtask
    // read: note the expected answer, the monitor compares it
    task automatic rd(input logic [7:0] a, input logic [7:0] d);
        exp_q.push_back(a > ADDR_PERIPH ? {RESP_DECERR, 32'h0} : {RESP_OKAY, 24'h0, d});
        @(posedge CORE_CLK);
        ARVALID <= 1'h1;
        RREADY <= 1'h1;
        ARADDR <= {24'h0, a};
        do begin
            @(posedge CORE_CLK);
            if (ARREADY) ARVALID <= 1'h0;
        end while (!RVALID);
        RREADY <= 1'h0;
    endtask
    always @(posedge CORE_CLK) begin
        if (RVALID && RREADY) cmp({RRESP, RDATA}, exp_q.pop_front());
        if (BVALID && BREADY) cmp_b(BRESP, bexp_q.pop_front());
    end
    task automatic give_verdict();
        $display("compares %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    initial begin
        #100000;
        fails++;
        give_verdict();
    end
    initial begin
        lat = 8'($random(seed)) | 8'h10; // pin 4 high once it drives
        repeat (5) @(posedge CORE_CLK);
        RST <= 1'h0;
        rd(ADDR_DIR, 8'hFF);
        rd(ADDR_OPTION, 8'h80);
        rd(8'h14, 8'h00);
        wr(8'h14, 8'h5A);
        wr(ADDR_DATA, lat);
        wr(ADDR_DIR, 8'hF0);
        wr(ADDR_OPTION, 8'h00);
        repeat (2) @(posedge CORE_CLK);
        #1;
        chk(PIN_OE, 8'h0F);
        chk(PIN_O & 8'h0F, lat & 8'h0F);
        chk(PIN_PU, 8'hF0);
        chk({7'h0, EXT_IRQ_IN}, {7'h0, lat[0]});
        rd(ADDR_DATA, {4'h0, lat[3:0]});
        wr(ADDR_INTCTL, 8'h08);
        ext_lvl <= 8'h20;
        repeat (8) @(posedge CORE_CLK);
        rd(ADDR_INTCTL, 8'h09);
        chk({7'h0, PORT_CHANGE_IRQ}, 8'h01);
        chk({7'h0, WAKE}, 8'h01);
        wr(ADDR_INTCTL, 8'h08);
        rd(ADDR_INTCTL, 8'h09);
        rd(ADDR_DATA, {4'h2, lat[3:0]});
        wr(ADDR_INTCTL, 8'h08);
        rd(ADDR_INTCTL, 8'h08);
        chk({6'h0, WAKE, PORT_CHANGE_IRQ}, 8'h00);
        wr(ADDR_DIR, 8'hE0);
        repeat (8) @(posedge CORE_CLK);
        rd(ADDR_INTCTL, 8'h08);
        WSTRB <= 4'h0;
        wr(ADDR_DIR, 8'h00);
        WSTRB <= 4'h1;
        rd(ADDR_DIR, 8'hE0);
        wr(ADDR_PERIPH, 8'h01);
        rd(ADDR_PERIPH, 8'h01);
        #1;
        chk(PIN_OE, 8'h19);
        chk({7'h0, SECONDARY_OSC_ENABLE}, 8'h01);
        @(posedge CORE_CLK);
        PERIPH_OUT <= 8'($random(seed));
        PERIPH_DIR <= 8'($random(seed)) | 8'h08;
        PERIPH_EN <= 8'h08;
        PROG_MODE <= 1'h1;
        PROG_DATA_OE <= 1'h1;
        PROG_DATA_OUT <= lat[7];
        ext_lvl <= 8'h2A;
        repeat (5) @(posedge CORE_CLK);
        #1;
        chk(PIN_OE, 8'h91);
        chk(PIN_O & 8'h80, lat & 8'h80);
        chk({2'h0, PROG_DATA_IN, PROG_CLK_IN, CAPTURE_IN, OSC_IN, TMR_CLK_IN, EXT_IRQ_IN},
            {2'h0, lat[7], 4'h5, lat[0]});
        give_verdict();
    end
endmodule
